// ### pcrb_consts.vh
// register offsets, field positions and reset values of the paged register bank
`ifndef PCRB_CONSTS_VH
`define PCRB_CONSTS_VH
`define PCRB_ADDR_PAGE 8'hFF
`define PCRB_ADDR_PASS 8'hEA
`define PCRB_ADDR_MSTAT 8'hF7
`define PCRB_ADDR_CLKSRC 8'hE0
`define PCRB_ADDR_TXOUT 8'hE6
`define PCRB_ADDR_SPREAD 8'hE7
`define PCRB_ADDR_VLATCH 8'hF2
`define PCRB_ADDR_DITHCTL 8'h08
`define PCRB_ADDR_DITHINC 8'h09
`define PCRB_ADDR_CORING 8'h2F
`define PCRB_ADDR_MOSQ 8'h31
`define PCRB_PAGE_GRC 5'h1D
`define PCRB_PAGE_DITH 5'h1F
`define PCRB_PAGE_MAX 5'h1B
`define PCRB_MASK_PAGE 8'h1F
`define PCRB_MASK_PASS 8'h01
`define PCRB_MASK_CLKSRC 8'h08
`define PCRB_MASK_TXOUT 8'h16
`define PCRB_MASK_SPREAD 8'h3F
`define PCRB_MASK_VLATCH 8'h01
`define PCRB_MASK_DITHCTL 8'h7F
`define PCRB_MASK_DITHINC 8'h03
`define PCRB_MASK_CORING 8'h77
`define PCRB_MASK_MOSQ 8'hF7
`define PCRB_RST_BYTE 8'h00
`define PCRB_BIT_CLKSRC 3
`define PCRB_BIT_SWING 4
`define PCRB_BIT_TXA 1
`define PCRB_BIT_TXB 2
`define PCRB_BIT_SSEN 2
`define PCRB_BIT_SSEL 3
`define PCRB_BIT_VLTEN 0
`define PCRB_BIT_PASS 0
`endif

// ### pcrb_sync2.v
// two flip-flop synchroniser for a single level
`timescale 1ns/1ps
module pcrb_sync2 (
  input wire clk,
  input wire rst,
  input wire din,
  output wire dout
);
  reg stage1_r;
  reg stage2_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end
  assign dout = stage2_r;
endmodule

// ### pcrb_shadow.v
// vsync-latched active copy of a shadow register
`timescale 1ns/1ps
`include "pcrb_consts.vh"
module pcrb_shadow #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] shadowIn,
  input wire load,
  output reg [W-1:0] activeOut
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      activeOut <= {W{1'b0}};
    end else if (load) begin
      activeOut <= shadowIn;
    end
  end
endmodule

// ### pcrb_register_bank.v
// paged control register bank with common registers and vsync latching
// Functional notes
// - page field at FFh selects register page
// - common registers reachable on any page
// - latched registers transfer shadow at vsync
// - latch enable F2h[0] gates vsync transfer
// - latch enable resets to zero
// - EAh[0] enables slave to master pass-through
// - F7h[0] reads master busy
// - F7h[2:1] reads eeprom error status
// - E0h[3] selects video clock link
// - E6h[4] selects transmitter swing
// - E6h[1] link A, [2] link B enables
// - E7h[2] enables clock spreader
// - E7h[1:0] frequency, [5:4] ratio selects
// - fields honour read/write direction
`timescale 1ns/1ps
`include "pcrb_consts.vh"
module pcrb_register_bank (
  input wire clk,
  input wire rst,
  input wire wrStb,
  input wire rdStb,
  input wire [7:0] subAddr,
  input wire [7:0] wrData,
  output reg [7:0] rdData_r,
  output reg rdValid_r,
  input wire vsyncPin,
  input wire masterBusyIn,
  input wire [1:0] eepromErrIn,
  output wire [4:0] pageSelect,
  output wire busPassThroughEnable,
  output wire videoClockSourceSelect,
  output wire txSwingSelect,
  output wire txLinkAEnable,
  output wire txLinkBEnable,
  output wire txSpreadEnable,
  output wire [1:0] txSpreadFreqSelect,
  output wire txSpreadTypeSelect,
  output wire [1:0] txSpreadRatioSelect,
  output wire vsyncLatchEnable,
  output wire [2:0] verticalCoringLevel,
  output wire [2:0] horizontalCoringLevel,
  output wire [3:0] flatAreaNoiseLevel,
  output wire [2:0] edgeAreaNoiseLevel,
  output wire [2:0] ditherBitDepth,
  output wire [2:0] ditherPatternMode,
  output wire ditherEnable,
  output wire [1:0] ditherIncrement,
  output wire vsyncLoad
);
  // bit index of each register in the one-hot address select
  localparam IDX_PAGE = 0;
  localparam IDX_PASS = 1;
  localparam IDX_CLKSRC = 2;
  localparam IDX_TXOUT = 3;
  localparam IDX_SPREAD = 4;
  localparam IDX_VLATCH = 5;
  localparam IDX_MSTAT = 6;
  localparam IDX_DITHCTL = 7;
  localparam IDX_DITHINC = 8;
  localparam IDX_CORING = 9;
  localparam IDX_MOSQ = 10;

  reg [7:0] pageReg_r;
  reg [7:0] passReg_r;
  reg [7:0] clkSrcReg_r;
  reg [7:0] txOutReg_r;
  reg [7:0] spreadReg_r;
  reg [7:0] vlatchReg_r;
  reg [7:0] dithCtlReg_r;
  reg [7:0] dithIncReg_r;
  reg [7:0] coringReg_r;
  reg [7:0] mosqReg_r;
  reg [7:0] rdData_nxt;
  reg vsyncPrev_r;
  wire vsyncSync;
  wire [7:0] dithCtlAct;
  wire [7:0] dithIncAct;
  wire [7:0] coringAct;
  wire [7:0] mosqAct;
  wire pageDith;
  wire pageGrc;
  wire [10:0] addrSel;
  wire vsyncRise;
  wire [7:0] statusByte;

  // masked write keeps reserved positions at zero
  function [7:0] pcrbMask;
    input [7:0] data;
    input [7:0] mask;
    begin
      pcrbMask = data & mask;
    end
  endfunction

  // page register match on the five page bits
  function pcrbPageIs;
    input [7:0] pageByte;
    input [4:0] page;
    begin
      pcrbPageIs = (pageByte[4:0] == page);
    end
  endfunction

  // one-hot select of the addressed register, common ones ahead of page
  function [10:0] pcrbDecode;
    input [7:0] addr;
    input dith;
    input gradation_creation;
    begin
      pcrbDecode = 11'h000;
      if (addr == `PCRB_ADDR_PAGE) begin
        pcrbDecode[IDX_PAGE] = 1'b1;
      end else if (addr == `PCRB_ADDR_PASS) begin
        pcrbDecode[IDX_PASS] = 1'b1;
      end else if (addr == `PCRB_ADDR_CLKSRC) begin
        pcrbDecode[IDX_CLKSRC] = 1'b1;
      end else if (addr == `PCRB_ADDR_TXOUT) begin
        pcrbDecode[IDX_TXOUT] = 1'b1;
      end else if (addr == `PCRB_ADDR_SPREAD) begin
        pcrbDecode[IDX_SPREAD] = 1'b1;
      end else if (addr == `PCRB_ADDR_VLATCH) begin
        pcrbDecode[IDX_VLATCH] = 1'b1;
      end else if (addr == `PCRB_ADDR_MSTAT) begin
        pcrbDecode[IDX_MSTAT] = 1'b1;
      end else if (dith && addr == `PCRB_ADDR_DITHCTL) begin
        pcrbDecode[IDX_DITHCTL] = 1'b1;
      end else if (dith && addr == `PCRB_ADDR_DITHINC) begin
        pcrbDecode[IDX_DITHINC] = 1'b1;
      end else if (gradation_creation && addr == `PCRB_ADDR_CORING) begin
        pcrbDecode[IDX_CORING] = 1'b1;
      end else if (gradation_creation && addr == `PCRB_ADDR_MOSQ) begin
        pcrbDecode[IDX_MOSQ] = 1'b1;
      end
    end
  endfunction

  pcrb_sync2 uVsyncSync (
    .clk(clk),
    .rst(rst),
    .din(vsyncPin),
    .dout(vsyncSync)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vsyncPrev_r <= 1'b0;
    end else begin
      vsyncPrev_r <= vsyncSync;
    end
  end

  // rising edge of the synchronised vsync level
  assign vsyncRise = vsyncSync & ~vsyncPrev_r;

  // latch event only while latch enabled
  assign vsyncLoad = vsyncRise & vlatchReg_r[`PCRB_BIT_VLTEN];

  assign pageDith = pcrbPageIs(pageReg_r, `PCRB_PAGE_DITH);
  assign pageGrc = pcrbPageIs(pageReg_r, `PCRB_PAGE_GRC);

  // one address decode shared by write and read
  assign addrSel = pcrbDecode(subAddr, pageDith, pageGrc);

  // status byte, read only
  assign statusByte = {5'h00, eepromErrIn, masterBusyIn};

  // register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pageReg_r <= `PCRB_RST_BYTE;
      passReg_r <= `PCRB_RST_BYTE;
      clkSrcReg_r <= `PCRB_RST_BYTE;
      txOutReg_r <= `PCRB_RST_BYTE;
      spreadReg_r <= `PCRB_RST_BYTE;
      vlatchReg_r <= `PCRB_RST_BYTE;
      dithCtlReg_r <= `PCRB_RST_BYTE;
      dithIncReg_r <= `PCRB_RST_BYTE;
      coringReg_r <= `PCRB_RST_BYTE;
      mosqReg_r <= `PCRB_RST_BYTE;
    end else if (wrStb) begin
      // common registers decoded ahead of page
      if (addrSel[IDX_PAGE]) begin
        pageReg_r <= pcrbMask(wrData, `PCRB_MASK_PAGE);
      end else if (addrSel[IDX_PASS]) begin
        passReg_r <= pcrbMask(wrData, `PCRB_MASK_PASS);
      end else if (addrSel[IDX_CLKSRC]) begin
        clkSrcReg_r <= pcrbMask(wrData, `PCRB_MASK_CLKSRC);
      end else if (addrSel[IDX_TXOUT]) begin
        txOutReg_r <= pcrbMask(wrData, `PCRB_MASK_TXOUT);
      end else if (addrSel[IDX_SPREAD]) begin
        spreadReg_r <= pcrbMask(wrData, `PCRB_MASK_SPREAD);
      end else if (addrSel[IDX_VLATCH]) begin
        vlatchReg_r <= pcrbMask(wrData, `PCRB_MASK_VLATCH);
      end else if (addrSel[IDX_MSTAT]) begin
        // status byte ignores writes
        pageReg_r <= pageReg_r;
      end else if (addrSel[IDX_DITHCTL]) begin
        dithCtlReg_r <= pcrbMask(wrData, `PCRB_MASK_DITHCTL);
      end else if (addrSel[IDX_DITHINC]) begin
        dithIncReg_r <= pcrbMask(wrData, `PCRB_MASK_DITHINC);
      end else if (addrSel[IDX_CORING]) begin
        coringReg_r <= pcrbMask(wrData, `PCRB_MASK_CORING);
      end else if (addrSel[IDX_MOSQ]) begin
        mosqReg_r <= pcrbMask(wrData, `PCRB_MASK_MOSQ);
      end
    end
  end

  // read decode, registered data
  always @* begin
    rdData_nxt = 8'h00;
    if (addrSel[IDX_PAGE]) begin
      rdData_nxt = pageReg_r;
    end else if (addrSel[IDX_PASS]) begin
      rdData_nxt = passReg_r;
    end else if (addrSel[IDX_CLKSRC]) begin
      rdData_nxt = clkSrcReg_r;
    end else if (addrSel[IDX_TXOUT]) begin
      rdData_nxt = txOutReg_r;
    end else if (addrSel[IDX_SPREAD]) begin
      rdData_nxt = spreadReg_r;
    end else if (addrSel[IDX_VLATCH]) begin
      rdData_nxt = vlatchReg_r;
    end else if (addrSel[IDX_MSTAT]) begin
      rdData_nxt = statusByte;
    end else if (addrSel[IDX_DITHCTL]) begin
      rdData_nxt = dithCtlReg_r;
    end else if (addrSel[IDX_DITHINC]) begin
      rdData_nxt = dithIncReg_r;
    end else if (addrSel[IDX_CORING]) begin
      rdData_nxt = coringReg_r;
    end else if (addrSel[IDX_MOSQ]) begin
      rdData_nxt = mosqReg_r;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= rdStb;
      if (rdStb) begin
        rdData_r <= rdData_nxt;
      end
    end
  end

  // vsync-latched active copies of picture registers
  pcrb_shadow #(.W(8)) uDithCtl (
    .clk(clk),
    .rst(rst),
    .shadowIn(dithCtlReg_r),
    .load(vsyncLoad),
    .activeOut(dithCtlAct)
  );
  pcrb_shadow #(.W(8)) uDithInc (
    .clk(clk),
    .rst(rst),
    .shadowIn(dithIncReg_r),
    .load(vsyncLoad),
    .activeOut(dithIncAct)
  );
  pcrb_shadow #(.W(8)) uCoring (
    .clk(clk),
    .rst(rst),
    .shadowIn(coringReg_r),
    .load(vsyncLoad),
    .activeOut(coringAct)
  );
  pcrb_shadow #(.W(8)) uMosq (
    .clk(clk),
    .rst(rst),
    .shadowIn(mosqReg_r),
    .load(vsyncLoad),
    .activeOut(mosqAct)
  );

  // levels of common registers
  assign pageSelect = pageReg_r[4:0];
  assign busPassThroughEnable = passReg_r[`PCRB_BIT_PASS];
  assign videoClockSourceSelect = clkSrcReg_r[`PCRB_BIT_CLKSRC];
  assign txSwingSelect = txOutReg_r[`PCRB_BIT_SWING];
  assign txLinkAEnable = txOutReg_r[`PCRB_BIT_TXA];
  assign txLinkBEnable = txOutReg_r[`PCRB_BIT_TXB];
  assign txSpreadEnable = spreadReg_r[`PCRB_BIT_SSEN];
  assign txSpreadFreqSelect = spreadReg_r[1:0];
  assign txSpreadTypeSelect = spreadReg_r[`PCRB_BIT_SSEL];
  assign txSpreadRatioSelect = spreadReg_r[5:4];
  assign vsyncLatchEnable = vlatchReg_r[`PCRB_BIT_VLTEN];
  // fields of active picture copies
  assign verticalCoringLevel = coringAct[6:4];
  assign horizontalCoringLevel = coringAct[2:0];
  assign flatAreaNoiseLevel = mosqAct[7:4];
  assign edgeAreaNoiseLevel = mosqAct[2:0];
  assign ditherBitDepth = dithCtlAct[6:4];
  assign ditherPatternMode = dithCtlAct[3:1];
  assign ditherEnable = dithCtlAct[0];
  assign ditherIncrement = dithIncAct[1:0];
endmodule

// ### pcrb_register_bank_properties.sv
// concurrent checks on the ports of the paged register bank
`timescale 1ns/1ps
module pcrb_checker (
  input wire clk,
  input wire rst,
  input wire wrStb,
  input wire rdStb,
  input wire [7:0] subAddr,
  input wire [7:0] wrData,
  input wire [7:0] rdData_r,
  input wire rdValid_r,
  input wire masterBusyIn,
  input wire [1:0] eepromErrIn,
  input wire [4:0] pageSelect,
  input wire busPassThroughEnable,
  input wire videoClockSourceSelect,
  input wire vsyncLatchEnable,
  input wire ditherEnable,
  input wire vsyncLoad
);
  reg [7:0] wdPrev;
  reg [2:0] stPrev;
  always @(posedge clk) begin
    wdPrev <= wrData;
    stPrev <= {eepromErrIn, masterBusyIn};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_page_write: assert property (wrStb && subAddr == 8'hFF |=>
    pageSelect == wdPrev[4:0]) else $error("page select not written");
  a_pass_write: assert property (wrStb && subAddr == 8'hEA |=>
    busPassThroughEnable == wdPrev[0]) else $error("pass-through not written");
  a_clk_source: assert property (wrStb && subAddr == 8'hE0 |=>
    videoClockSourceSelect == wdPrev[3]) else $error("clock source not written");
  a_status_read: assert property (rdStb && subAddr == 8'hF7 |=>
    rdValid_r && rdData_r == {5'h00, stPrev}) else $error("status read wrong");
  a_reserved_zero: assert property (rdStb && subAddr == 8'hE0 |=>
    rdData_r[7:4] == 4'h0 && rdData_r[2:0] == 3'h0) else $error("reserved bits set");
  a_load_enable: assert property (vsyncLoad |-> vsyncLatchEnable)
    else $error("load while latch off");
  a_load_pulse: assert property (vsyncLoad |=> !vsyncLoad)
    else $error("load longer than one cycle");
  a_active_hold: assert property (!vsyncLoad |=> $stable(ditherEnable))
    else $error("active value moved without load");
  a_valid_cause: assert property ($rose(rdValid_r) |-> $past(rdStb))
    else $error("read valid without request");
endmodule
bind pcrb_register_bank pcrb_checker chk_u (.clk, .rst, .wrStb, .rdStb, .subAddr, .wrData,
  .rdData_r, .rdValid_r, .masterBusyIn, .eepromErrIn, .pageSelect, .busPassThroughEnable,
  .videoClockSourceSelect, .vsyncLatchEnable, .ditherEnable, .vsyncLoad);

// ### pcrb_vsync_src.sv
// vertical sync source, one pulse per request, timed by the 80 ns link period
`timescale 1ns/1ps
module pcrb_vsync_src (
  input wire go,
  output reg vsyncPin
);
  localparam LINK = 80;
  initial vsyncPin = 1'b0;
  always @(posedge go) begin
    #(LINK / 2) vsyncPin = 1'b1;
    #(LINK * 2) vsyncPin = 1'b0;
  end
endmodule

// ### tb.sv
// self-checking bench for the paged register bank
`timescale 1ns/1ps
module tb;
  reg clk, rst, wrStb, rdStb, masterBusyIn, vGo, seen;
  reg [7:0] subAddr, wrData, d, a, pg;
  reg [1:0] eepromErrIn;
  reg [7:0] m [0:4];
  integer seed = 17, errors = 0, samples_checked = 0, i, j, k;
  localparam [39:0] ADS = 40'hEA_E0E6_E7F2;
  localparam [39:0] MKS = 40'h01_0816_3F01;
  wire [7:0] rdData_r;
  wire [4:0] pageSelect;
  wire [3:0] flatAreaNoiseLevel;
  wire [2:0] verticalCoringLevel, horizontalCoringLevel, edgeAreaNoiseLevel;
  wire [2:0] ditherBitDepth, ditherPatternMode;
  wire [1:0] txSpreadFreqSelect, txSpreadRatioSelect, ditherIncrement;
  wire rdValid_r, vsyncPin, vsyncLoad, busPassThroughEnable, videoClockSourceSelect;
  wire txSwingSelect, txLinkAEnable, txLinkBEnable, txSpreadEnable, txSpreadTypeSelect;
  wire vsyncLatchEnable, ditherEnable;
  pcrb_vsync_src vs_u (.go(vGo), .vsyncPin(vsyncPin));
  pcrb_register_bank dut_u (.clk, .rst, .wrStb, .rdStb, .subAddr, .wrData, .rdData_r,
    .rdValid_r, .vsyncPin, .masterBusyIn, .eepromErrIn, .pageSelect, .busPassThroughEnable,
    .videoClockSourceSelect, .txSwingSelect, .txLinkAEnable, .txLinkBEnable, .txSpreadEnable,
    .txSpreadFreqSelect, .txSpreadTypeSelect, .txSpreadRatioSelect, .vsyncLatchEnable,
    .verticalCoringLevel, .horizontalCoringLevel, .flatAreaNoiseLevel, .edgeAreaNoiseLevel,
    .ditherBitDepth, .ditherPatternMode, .ditherEnable, .ditherIncrement, .vsyncLoad);
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] ad, input [7:0] v);
    begin
      @(negedge clk);
      wrStb = 1;
      subAddr = ad;
      wrData = v;
      @(negedge clk);
      wrStb = 0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    begin
      @(negedge clk);
      rdStb = 1;
      subAddr = ad;
      @(negedge clk);
      rdStb = 0;
      chk(rdValid_r, 1);
      chk(rdData_r, e);
    end
  endtask
  task vs(input e);
    begin
      seen = 0;
      vGo = 1;
      for (k = 0; k < 60; k = k + 1) begin
        @(negedge clk);
        if (vsyncLoad === 1'b1) seen = 1;
      end
      vGo = 0;
      chk(seen, e);
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1;
    {wrStb, rdStb, masterBusyIn, vGo, subAddr, wrData, eepromErrIn} = 0;
    for (i = 0; i < 5; i = i + 1) m[i] = 8'h00;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 0;
    for (i = 0; i < 5; i = i + 1) rd(ADS[39 - 8 * i -: 8], 8'h00);
    rd(8'hFF, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      j = {$random(seed)} % 5;
      a = ADS[39 - 8 * j -: 8];
      d = $random(seed);
      pg = $random(seed);
      if (a == 8'hE7) d[3] = 1'b0;
      wr(8'hFF, pg);
      rd(8'hFF, pg & 8'h1F);
      wr(a, d);
      m[j] = d & MKS[39 - 8 * j -: 8];
      rd(a, m[j]);
      chk({vsyncLatchEnable, pageSelect, txSwingSelect, txLinkBEnable, txLinkAEnable,
        videoClockSourceSelect, busPassThroughEnable}, {m[4][0], pg[4:0], m[2][4], m[2][2],
        m[2][1], m[1][3], m[0][0]});
      chk({txSpreadRatioSelect, txSpreadTypeSelect, txSpreadEnable, txSpreadFreqSelect},
        m[3][5:0]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      {eepromErrIn, masterBusyIn} = {i[2:1], 1'b0};
      wr(8'hF7, 8'hFF);
      masterBusyIn = i[0];
      rd(8'hF7, i[7:0]);
    end
    masterBusyIn = 0;
    rd(8'h50, 8'h00);
    wr(8'hF2, 8'h00);
    wr(8'hFF, 8'h1D);
    wr(8'h2F, 8'h55);
    wr(8'hFF, 8'h00);
    rd(8'h2F, 8'h00);
    wr(8'hFF, 8'h1D);
    d = $random(seed);
    wr(8'h31, d);
    vs(0);
    chk({verticalCoringLevel, flatAreaNoiseLevel}, 0);
    rd(8'h31, d & 8'hF7);
    wr(8'hF2, 8'h01);
    vs(1);
    chk({verticalCoringLevel, horizontalCoringLevel, flatAreaNoiseLevel, edgeAreaNoiseLevel},
      {6'h2D, d[7:4], d[2:0]});
    wr(8'hFF, 8'h1F);
    d = $random(seed);
    wr(8'hF2, 8'h00);
    wr(8'h08, d);
    wr(8'h09, d);
    wr(8'hF2, 8'h01);
    vs(1);
    chk({ditherBitDepth, ditherPatternMode, ditherEnable, ditherIncrement},
      {d[6:0], d[1:0]});
    rd(8'h08, d & 8'h7F);
    print_verdict;
  end
endmodule
